// ### stup_cfg.svh
// constants for the stencil test and update unit
// assumes inclusion by the unit and the testbench
`ifndef STUP_CFG_SVH
`define STUP_CFG_SVH
`define STUP_ADDR_CTRL      8'h00
`define STUP_ADDR_STENCIL   8'h04
`define STUP_ADDR_CONST     8'h08
`define STUP_ADDR_PINSEL    8'h0C
`define STUP_ADDR_BLEND     8'h10
`define STUP_ADDR_STATUS    8'h14
`define STUP_REFSRC_BIT     19
`define STUP_PINSEL0_BIT    0
`define STUP_PINSEL1_BIT    8
`define STUP_BLEND_EN_BIT   27
`define STUP_CTRL_RESET     32'h0000_0000
`define STUP_STENCIL_RESET  32'h0000_00FF
`define STUP_CONST_RESET    32'h0000_0000
`define STUP_PINSEL_RESET   32'h0000_0000
`define STUP_BLEND_RESET    32'h0000_0000
`define STUP_RESP_OKAY      2'b00
`define STUP_RESP_SLVERR    2'b10
`endif

// ### stup_pkg.sv
// types for the stencil test and update unit
// assumes stup_cfg.svh constants alongside
package stup_pkg;
    typedef enum logic [2:0] {
        STUP_F_NEVER = 3'b000, STUP_F_LESS = 3'b001, STUP_F_EQUAL = 3'b010, STUP_F_LEQUAL = 3'b011,
        STUP_F_GREATER = 3'b100, STUP_F_NOTEQUAL = 3'b101, STUP_F_GEQUAL = 3'b110, STUP_F_ALWAYS = 3'b111
    } stup_func_t;
    typedef enum logic [2:0] {
        STUP_OP_KEEP = 3'b000, STUP_OP_ZERO = 3'b001, STUP_OP_REPLACE = 3'b010,
        STUP_OP_INCR = 3'b011, STUP_OP_DECR = 3'b100, STUP_OP_INVERT = 3'b101
    } stup_op_t;
    typedef enum logic [1:0] {
        STUP_SF_ONE = 2'b00, STUP_SF_ALPHA_SAT = 2'b01, STUP_SF_CONST = 2'b10, STUP_SF_SRC_ALPHA = 2'b11
    } stup_sfactor_t;
endpackage : stup_pkg

// ### stup_unit.sv
// stencil test, stencil update and top-lane blend datapath behind an AXI4-Lite slave
// assumes one 100 MHz clock and pixel pins synchronous to it
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "stup_cfg.svh"

// Function
// RULE1: top byte holds eight individually enabled planes
// RULE2: reference from pins or constant register
// RULE3: masked eight-way compare of reference and old
// RULE4: per-case zero keep invert replace incr decr
// RULE5: pass-in qualified by select, gated with match
// RULE6: gate fail writes nothing, pass-out low
// RULE7: stencil fail writes top byte, pass-out low
// RULE8: all pass writes four bytes, pass-out high
// RULE9: depth fail writes top byte, pass-out low
// RULE10: increment and decrement clamp, never wrap
// RULE11: controller never enables both stencil modes
// RULE12: alpha saturate uses min for colour, one alpha
// RULE13: blend is preblend then normal loop-back cycle
// RULE14: controller keeps top-lane blending off with stencil
// RULE15: controller keeps enabled planes contiguous
// RULE16: decision made in the same pipelined slot
module stup_unit (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // pixel slot inputs
    input  wire logic        pix_valid,
    input  wire logic [31:0] pixel_data_pins,
    input  wire logic [31:0] old_pixel,
    input  wire logic [31:0] rop_result,
    input  wire logic [1:0]  pass_in,
    input  wire logic        match_pass,
    input  wire logic        depth_pass,
    // pixel slot outputs
    output logic             wr_valid,
    output logic [3:0]       write_enable_byte,
    output logic [31:0]      write_data,
    output logic             pass_out,
    // blend lane inputs and result
    input  wire logic        blend_start,
    input  wire logic [7:0]  src_colour,
    input  wire logic [7:0]  src_alpha,
    input  wire logic [7:0]  dst_colour,
    input  wire logic [7:0]  dst_alpha,
    input  wire logic [7:0]  dst_factor,
    output logic             blend_valid,
    output logic [7:0]       blend_colour,
    output logic [7:0]       blend_alpha
);
    // control: [2:0] func, [5:3] fail op, [8:6] zpass op, [11:9] zfail op, [19] ref source, [21:20] sfactor
    logic [31:0] stencil_control_reg;
    logic [31:0] stencil_plane_enables;   // [7:0] planes, [15:8] compare mask
    logic [31:0] const_source_reg;
    logic [31:0] pass_in_select_reg;
    logic [31:0] rop_blend_control_reg;
    logic [31:0] status_reg;              // pass and write counts, last outcome

    // scaled 8-bit product, rounded and divided by 256
    function automatic logic [7:0] stup_mul(input logic [7:0] a, input logic [7:0] b);
        logic [15:0] p;
        p = 16'(a) * 16'(b);
        return p[15:8] + {7'h00, p[7]};
    endfunction : stup_mul

    // one stencil operation on the enabled planes
    function automatic logic [7:0] stup_apply(input logic [2:0] op, input logic [7:0] ref_b,
                                              input logic [7:0] old, input logic [7:0] en);
        logic [7:0] field;
        logic [7:0] one;
        logic [7:0] r;
        one = en & ~(en << 1);             // lowest enabled plane aligns the count
        field = old & en;
        r = old;
        case (op)
            3'b001:  r = 8'h00;                                           // see RULE4
            3'b010:  r = ref_b;
            3'b101:  r = ~old;
            3'b011:  r = (field == en) ? old : old + one;                  // see RULE10
            3'b100:  r = (field == 8'h00) ? old : old - one;               // see RULE10
            default: r = old;
        endcase
        return (r & en) | (old & ~en);                                    // see RULE1
    endfunction : stup_apply

    // decoded fields
    logic [7:0] ref_byte;
    logic [7:0] planes;
    logic [7:0] cmp_mask;
    logic [7:0] ref_m;
    logic [7:0] old_m;
    logic       stencil_test;
    logic       gate;
    stup_pkg::stup_func_t stencil_compare_function;
    assign planes   = stencil_plane_enables[7:0];
    assign cmp_mask = stencil_plane_enables[15:8];
    assign stencil_compare_function = stup_pkg::stup_func_t'(stencil_control_reg[2:0]);
    // reference byte source
    assign ref_byte = stencil_control_reg[`STUP_REFSRC_BIT] ? const_source_reg[31:24]
                                                            : pixel_data_pins[31:24]; // see RULE2
    assign ref_m = ref_byte & cmp_mask;
    assign old_m = old_pixel[31:24] & cmp_mask;

    // masked comparison
    always_comb begin
        case (stencil_compare_function)                                   // see RULE3
            stup_pkg::STUP_F_NEVER:    stencil_test = 1'b0;
            stup_pkg::STUP_F_LESS:     stencil_test = ref_m < old_m;
            stup_pkg::STUP_F_EQUAL:    stencil_test = ref_m == old_m;
            stup_pkg::STUP_F_LEQUAL:   stencil_test = ref_m <= old_m;
            stup_pkg::STUP_F_GREATER:  stencil_test = ref_m > old_m;
            stup_pkg::STUP_F_NOTEQUAL: stencil_test = ref_m != old_m;
            stup_pkg::STUP_F_GEQUAL:   stencil_test = ref_m >= old_m;
            default:                   stencil_test = 1'b1;
        endcase
    end

    // qualified pass-in and match gate
    assign gate = (!pass_in_select_reg[`STUP_PINSEL0_BIT] | pass_in[0]) &
                  (!pass_in_select_reg[`STUP_PINSEL1_BIT] | pass_in[1]) & match_pass; // see RULE5

    // write decision, registered in the same read-modify-write slot
    logic [3:0]  next_we;
    logic [7:0]  next_top;
    logic        next_pass;
    always_comb begin
        next_we   = 4'b0000;
        next_top  = old_pixel[31:24];
        next_pass = 1'b0;
        if (!gate) begin
            next_we = 4'b0000;                                            // see RULE6
        end else if (!stencil_test) begin
            next_we  = 4'b1000;                                           // see RULE7
            next_top = stup_apply(stencil_control_reg[5:3], ref_byte, old_pixel[31:24], planes);
        end else if (depth_pass) begin
            next_we   = 4'b1111;                                          // see RULE8
            next_top  = (stup_apply(stencil_control_reg[8:6], ref_byte, old_pixel[31:24], planes) & planes)
                      | (rop_result[31:24] & ~planes);
            next_pass = 1'b1;
        end else begin
            next_we  = 4'b1000;                                           // see RULE9
            next_top = stup_apply(stencil_control_reg[11:9], ref_byte, old_pixel[31:24], planes);
        end
    end

    // pixel slot output register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_valid          <= 1'b0;
            write_enable_byte <= 4'b0000;
            write_data        <= 32'h0000_0000;
            pass_out          <= 1'b0;
        end else begin
            wr_valid          <= pix_valid;                               // see RULE16
            write_enable_byte <= pix_valid ? next_we : 4'b0000;
            write_data        <= {next_top, rop_result[23:0]};
            pass_out          <= pix_valid & next_pass;
        end
    end

    // top-lane blend: preblend then normal cycle
    stup_pkg::stup_sfactor_t sfactor;
    logic [7:0] sat_f;
    logic [7:0] pre_c;
    logic [7:0] pre_a;
    logic       pre_valid;
    assign sfactor = stup_pkg::stup_sfactor_t'(stencil_control_reg[21:20]);
    assign sat_f   = (src_alpha < ~dst_alpha) ? src_alpha : ~dst_alpha;   // see RULE12
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_valid <= 1'b0;
            pre_c     <= 8'h00;
            pre_a     <= 8'h00;
        end else begin
            pre_valid <= blend_start & rop_blend_control_reg[`STUP_BLEND_EN_BIT]; // see RULE13
            case (sfactor)
                stup_pkg::STUP_SF_ALPHA_SAT: begin
                    pre_c <= stup_mul(src_colour, sat_f);                 // see RULE12
                    pre_a <= src_alpha;
                end
                stup_pkg::STUP_SF_CONST: begin
                    pre_c <= stup_mul(src_colour, const_source_reg[31:24]);
                    pre_a <= stup_mul(src_alpha, const_source_reg[31:24]);
                end
                stup_pkg::STUP_SF_SRC_ALPHA: begin
                    pre_c <= stup_mul(src_colour, src_alpha);
                    pre_a <= stup_mul(src_alpha, src_alpha);
                end
                default: begin
                    pre_c <= src_colour;
                    pre_a <= src_alpha;
                end
            endcase
        end
    end
    // normal cycle adds destination term to looped-back preblend
    logic [8:0] sum_c;
    logic [8:0] sum_a;
    assign sum_c = {1'b0, stup_mul(dst_factor, dst_colour)} + {1'b0, pre_c};
    assign sum_a = {1'b0, stup_mul(dst_factor, dst_alpha)} + {1'b0, pre_a};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blend_valid  <= 1'b0;
            blend_colour <= 8'h00;
            blend_alpha  <= 8'h00;
        end else begin
            blend_valid  <= pre_valid;                                    // see RULE13
            blend_colour <= sum_c[8] ? 8'hFF : sum_c[7:0];
            blend_alpha  <= sum_a[8] ? 8'hFF : sum_a[7:0];
        end
    end

    // AXI4-Lite write path: address and data in either order
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // byte-lane merge of a write
    function automatic logic [31:0] stup_merge(input logic [31:0] cur, input logic [31:0] d,
                                               input logic [3:0] s);
        logic [31:0] r;
        r = cur;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction : stup_merge

    // register writes and write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stencil_control_reg   <= `STUP_CTRL_RESET;
            stencil_plane_enables <= `STUP_STENCIL_RESET;
            const_source_reg      <= `STUP_CONST_RESET;
            pass_in_select_reg    <= `STUP_PINSEL_RESET;
            rop_blend_control_reg <= `STUP_BLEND_RESET;
            s_axi_bvalid          <= 1'b0;
            s_axi_bresp           <= `STUP_RESP_OKAY;
        end else begin
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `STUP_RESP_OKAY;
                if (aw_addr == `STUP_ADDR_CTRL) begin
                    stencil_control_reg <= stup_merge(stencil_control_reg, w_data, w_strb);
                end else if (aw_addr == `STUP_ADDR_STENCIL) begin
                    stencil_plane_enables <= stup_merge(stencil_plane_enables, w_data, w_strb);
                end else if (aw_addr == `STUP_ADDR_CONST) begin
                    const_source_reg <= stup_merge(const_source_reg, w_data, w_strb);
                end else if (aw_addr == `STUP_ADDR_PINSEL) begin
                    pass_in_select_reg <= stup_merge(pass_in_select_reg, w_data, w_strb);
                end else if (aw_addr == `STUP_ADDR_BLEND) begin
                    rop_blend_control_reg <= stup_merge(rop_blend_control_reg, w_data, w_strb);
                end else if (aw_addr != `STUP_ADDR_STATUS) begin
                    s_axi_bresp <= `STUP_RESP_SLVERR;
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // status: [15:0] pass-out count, [29:16] write count, [31] last pass, [30] last gate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_reg <= 32'h0000_0000;
        end else if (pix_valid) begin
            status_reg[15:0]  <= status_reg[15:0] + {15'h0000, next_pass};
            status_reg[29:16] <= status_reg[29:16] + {13'h0000, next_we != 4'b0000};
            status_reg[30]    <= gate;
            status_reg[31]    <= next_pass;
        end
    end

    // read path
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `STUP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `STUP_RESP_OKAY;
            if (s_axi_araddr == `STUP_ADDR_CTRL) begin
                s_axi_rdata <= stencil_control_reg;
            end else if (s_axi_araddr == `STUP_ADDR_STENCIL) begin
                s_axi_rdata <= stencil_plane_enables;
            end else if (s_axi_araddr == `STUP_ADDR_CONST) begin
                s_axi_rdata <= const_source_reg;
            end else if (s_axi_araddr == `STUP_ADDR_PINSEL) begin
                s_axi_rdata <= pass_in_select_reg;
            end else if (s_axi_araddr == `STUP_ADDR_BLEND) begin
                s_axi_rdata <= rop_blend_control_reg;
            end else if (s_axi_araddr == `STUP_ADDR_STATUS) begin
                s_axi_rdata <= status_reg;
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `STUP_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // checks
    a_gate_fail_quiet: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE6
        pix_valid && !gate |=> write_enable_byte == 4'b0000 && !pass_out) else $error("gate fail wrote");
    a_stencil_fail_top: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE7
        pix_valid && gate && !stencil_test |=> write_enable_byte == 4'b1000 && !pass_out)
        else $error("stencil fail lanes wrong");
    a_all_pass_full: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE8
        pix_valid && gate && stencil_test && depth_pass |=> write_enable_byte == 4'b1111 && pass_out)
        else $error("all pass lanes wrong");
    a_depth_fail_top: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE9
        pix_valid && gate && stencil_test && !depth_pass |=> write_enable_byte == 4'b1000 && !pass_out)
        else $error("depth fail lanes wrong");
    a_disabled_keep: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE1
        pix_valid && !(gate && stencil_test && depth_pass)
        |=> ((write_data[31:24] ^ $past(old_pixel[31:24])) & ~$past(planes)) == 8'h00)
        else $error("disabled plane changed");
    a_ref_select: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE2
        pix_valid && gate && !stencil_test && stencil_control_reg[5:3] == 3'b010
        |=> ((write_data[31:24] ^ $past(stencil_control_reg[`STUP_REFSRC_BIT] ? const_source_reg[31:24]
            : pixel_data_pins[31:24])) & $past(planes)) == 8'h00)
        else $error("reference source wrong");
    a_never_fails: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE3
        pix_valid && gate && stencil_control_reg[2:0] == 3'b000 |=> !pass_out)
        else $error("never passed");
    a_pass_in_gate: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE5
        pix_valid && pass_in_select_reg[`STUP_PINSEL0_BIT] && !pass_in[0] |=> write_enable_byte == 4'b0000)
        else $error("pass in ignored");
    a_incr_clamp: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE10
        pix_valid && gate && stencil_test && depth_pass && stencil_control_reg[8:6] == 3'b011
        && (old_pixel[31:24] & planes) == planes |=> (write_data[31:24] & $past(planes)) == $past(planes))
        else $error("increment wrapped");
    a_blend_two_cycle: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE13
        blend_start && rop_blend_control_reg[`STUP_BLEND_EN_BIT] |-> ##2 blend_valid)
        else $error("blend latency wrong");
    c_all_pass: cover property (@(posedge aclk) disable iff (!aresetn) pass_out);
    c_stencil_fail: cover property (@(posedge aclk) disable iff (!aresetn)
        pix_valid && gate && !stencil_test);
    c_depth_fail: cover property (@(posedge aclk) disable iff (!aresetn)
        pix_valid && gate && stencil_test && !depth_pass);
    c_blend: cover property (@(posedge aclk) disable iff (!aresetn) blend_valid);
endmodule : stup_unit

// ### stup_ctrl_model.sv
// rendering controller model: presents one pixel slot per request
// assumes a shared rising-edge aclk; the bench sets up the unit's registers
`timescale 1ns/1ps
module stup_ctrl_model (
    // clock
    input  wire logic        aclk,
    // pixel slot drive
    output logic             pix_valid,
    output logic [31:0]      pixel_data_pins,
    output logic [31:0]      old_pixel,
    output logic [31:0]      rop_result,
    output logic [1:0]       pass_in,
    output logic             match_pass,
    output logic             depth_pass
);
    // idle pins at time zero
    initial begin
        {pix_valid, pixel_data_pins, old_pixel, rop_result, pass_in, match_pass, depth_pass} = '0;
    end

    // one pixel; never selects decal mode, keeps planes contiguous, top-lane blend off
    task automatic send(input logic [7:0] rt, input logic [7:0] ot, input logic [7:0] pt,
                        input logic [1:0] pin, input logic mp, input logic dp);
        @(posedge aclk);
        pix_valid       <= 1'b1;
        pixel_data_pins <= {rt, 24'h00_0000};
        old_pixel       <= {ot, 24'h65_4321};
        rop_result      <= {pt, 24'h12_3456};
        pass_in         <= pin;
        match_pass      <= mp;
        depth_pass      <= dp;
        @(posedge aclk);
        // released pins show the inverse so stale values never pass
        pix_valid       <= 1'b0;
        pixel_data_pins <= ~pixel_data_pins;
        old_pixel       <= ~old_pixel;
    endtask : send
endmodule : stup_ctrl_model

// ### testbench.sv
// self-checking bench for the stencil test and update unit
// assumes stup_unit, stup_cfg.svh and stup_ctrl_model alongside
`timescale 1ns/1ps
`include "stup_cfg.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
    $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module testbench;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
    logic        pix_valid, match_pass, depth_pass, wr_valid, pass_out, blend_start, blend_valid;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, src_colour, src_alpha, dst_colour, dst_alpha, dst_factor;
    logic [7:0]  blend_colour, blend_alpha;
    logic [31:0] s_axi_wdata, s_axi_rdata, pixel_data_pins, old_pixel, rop_result, write_data;
    logic [3:0]  s_axi_wstrb, write_enable_byte;
    logic [1:0]  s_axi_bresp, s_axi_rresp, pass_in;
    logic [31:0] q;
    logic [1:0]  r;
    int          num_errors = 0, cmp_count = 0, cycles = 0;

    stup_unit dut (.*);
    stup_ctrl_model ctrl (.*);

    // free-running clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // hang guard
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            results();
        end
    end

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results

    // one AXI4-Lite write or read, held until each channel is taken
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        if (w) begin
            s_axi_awaddr  <= a;
            s_axi_wdata   <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid  <= 1'b1;
            s_axi_bready  <= 1'b1;
        end else begin
            s_axi_araddr  <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready  <= 1'b1;
        end
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if ((w && s_axi_bvalid) || (!w && s_axi_rvalid)) begin
                q = s_axi_rdata;
                r = w ? s_axi_bresp : s_axi_rresp;
                s_axi_bready <= 1'b0;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask : xfer

    task automatic cfg(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        `CHK(r, `STUP_RESP_OKAY)
    endtask : cfg

    // one pixel through the slot, outputs judged one cycle later
    task automatic px(input logic [7:0] rt, ot, pt, input logic [1:0] pin, input logic mp, dp,
                      input logic [3:0] we, input logic [7:0] top, input logic po);
        ctrl.send(rt, ot, pt, pin, mp, dp);
        #1;
        `CHK(wr_valid, 1'b1)
        `CHK(write_enable_byte, we)
        `CHK(pass_out, po)
        if (we !== 4'h0) `CHK(write_data, {top, 24'h12_3456})
    endtask : px

    // register reset value and unmapped address
    task automatic t_regs();
        xfer(1'b0, `STUP_ADDR_STENCIL, 32'h0000_0000);
        `CHK(q, `STUP_STENCIL_RESET)
        xfer(1'b0, 8'h3C, 32'h0000_0000);
        `CHK(r, `STUP_RESP_SLVERR)
    endtask : t_regs

    // gate and the three write cases: fail replace, pass invert, depth-fail zero
    task automatic t_cases();
        cfg(`STUP_ADDR_STENCIL, 32'h0000_FF0F);
        cfg(`STUP_ADDR_PINSEL, 32'h0000_0101);
        cfg(`STUP_ADDR_CTRL, 32'h0000_0357);
        px(8'h5A, 8'h33, 8'hC0, 2'b01, 1'b1, 1'b1, 4'h0, 8'h00, 1'b0);
        px(8'h5A, 8'h33, 8'hC0, 2'b10, 1'b1, 1'b1, 4'h0, 8'h00, 1'b0);
        px(8'h5A, 8'h33, 8'hC0, 2'b11, 1'b0, 1'b1, 4'h0, 8'h00, 1'b0);
        px(8'h5A, 8'h33, 8'hC0, 2'b11, 1'b1, 1'b1, 4'hF, 8'hCC, 1'b1);
        px(8'h5A, 8'h33, 8'hC0, 2'b11, 1'b1, 1'b0, 4'h8, 8'h30, 1'b0);
        cfg(`STUP_ADDR_PINSEL, 32'h0000_0000);
        px(8'h5A, 8'h33, 8'hC0, 2'b00, 1'b1, 1'b1, 4'hF, 8'hCC, 1'b1);
        cfg(`STUP_ADDR_CTRL, 32'h0000_0350);
        px(8'h5A, 8'h33, 8'hC0, 2'b00, 1'b1, 1'b1, 4'h8, 8'h3A, 1'b0);
    endtask : t_cases

    // all eight functions, below and masked-equal points
    task automatic t_compare();
        logic [7:0] lt, eq;
        lt = 8'b1010_1010;
        eq = 8'b1100_1100;
        cfg(`STUP_ADDR_STENCIL, 32'h0000_F00F);
        for (int f = 0; f < 8; f++) begin
            cfg(`STUP_ADDR_CTRL, 32'(f));
            px(8'h40, 8'h50, 8'hC0, 2'b00, 1'b1, 1'b1, lt[f] ? 4'hF : 4'h8, lt[f] ? 8'hC0 : 8'h50, lt[f]);
            px(8'h5F, 8'h50, 8'hC0, 2'b00, 1'b1, 1'b1, eq[f] ? 4'hF : 4'h8, eq[f] ? 8'hC0 : 8'h50, eq[f]);
        end
    endtask : t_compare

    // reference from constant register, then from pins
    task automatic t_refsrc();
        cfg(`STUP_ADDR_CONST, 32'h5A00_0000);
        cfg(`STUP_ADDR_CTRL, 32'h0008_0002);
        px(8'h00, 8'h53, 8'hC0, 2'b00, 1'b1, 1'b1, 4'hF, 8'hC3, 1'b1);
        cfg(`STUP_ADDR_CTRL, 32'h0000_0002);
        px(8'h00, 8'h53, 8'hC0, 2'b00, 1'b1, 1'b1, 4'h8, 8'h53, 1'b0);
    endtask : t_refsrc

    // increment and decrement clamp and align to the lowest plane
    task automatic t_clamp();
        cfg(`STUP_ADDR_STENCIL, 32'h0000_FFFF);
        cfg(`STUP_ADDR_CTRL, 32'h0000_08C7);
        px(8'h00, 8'hFF, 8'hC0, 2'b00, 1'b1, 1'b1, 4'hF, 8'hFF, 1'b1);
        px(8'h00, 8'h00, 8'hC0, 2'b00, 1'b1, 1'b0, 4'h8, 8'h00, 1'b0);
        px(8'h00, 8'h41, 8'hC0, 2'b00, 1'b1, 1'b1, 4'hF, 8'h42, 1'b1);
        cfg(`STUP_ADDR_STENCIL, 32'h0000_FFF0);
        px(8'h00, 8'h1F, 8'hC5, 2'b00, 1'b1, 1'b1, 4'hF, 8'h25, 1'b1);
        px(8'h00, 8'h0A, 8'hC5, 2'b00, 1'b1, 1'b0, 4'h8, 8'h0A, 1'b0);
        xfer(1'b0, `STUP_ADDR_STATUS, 32'h0000_0000);
        `CHK(q, 32'h401B_000E)
    endtask : t_clamp

    // one source factor through preblend and normal cycle, planes off
    task automatic t_blend(input logic [31:0] c, input logic [7:0] ec, ea);
        cfg(`STUP_ADDR_STENCIL, 32'h0000_FF00);
        cfg(`STUP_ADDR_CTRL, c);
        cfg(`STUP_ADDR_BLEND, 32'h0800_0000);
        @(posedge aclk);
        blend_start <= 1'b1;
        src_colour  <= 8'hFF;
        src_alpha   <= 8'h80;
        dst_alpha   <= 8'hC0;
        dst_colour  <= 8'h77;
        dst_factor  <= 8'h80;
        @(posedge aclk);
        blend_start <= 1'b0;
        @(posedge aclk);
        #1;
        `CHK(blend_valid, 1'b1)
        `CHK(blend_colour, ec)
        `CHK(blend_alpha, ea)
    endtask : t_blend

    // main sequence
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, blend_start} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, src_colour, src_alpha, dst_colour, dst_alpha, dst_factor} = '0;
        s_axi_wstrb = 4'hF;
        aresetn = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_cases();
        t_compare();
        t_refsrc();
        t_clamp();
        t_blend(32'h0010_0000, 8'h7B, 8'hE0);
        t_blend(32'h0020_0000, 8'h96, 8'h8D);
        results();
    end
endmodule : testbench
